// ==== design/rsvp_ctrl.v ====
// Reference selection and first-stage oscillator PLL control logic
`timescale 1ns/1ns
// Overview of operation
// - Extension select adds second feedback divider
// - Bypass bit routes around oscillator PLL
// - Polarity bit inverts control loop sense
// - Force-centre resets set, holds mid-supply
// - First pump code, reset 11000
// - Second pump code, reset 11000
// - Offset applied only when enabled
// - Power bit reads 0, output starts on
// - Format bit committed, starts emitter-coupled
// - Amplitude code committed, starts at top
// - Output config live only under unlock pattern
// - Two-bit priorities, input 0 wins ties
// - Pre-divider divides validation by four
// - Revertive ignored in manual-type modes
// - Revert only to higher priority input
// - Mode code decodes four modes, reset 0
// - Auto modes pick by loss and priority
// - Manual modes use select field
// - Hold-off countdown then switch over
// - Hold-off ticks from divided timebase
// - Hold-off reloads after reaching zero
// - Re-validation counter clears loss flag
`include "rsvp_map.vh"
module rsvp_ctrl #(
  parameter LOS_TIMEOUT   = 64,
  parameter HOLD_DIV_BASE = 15
) (
  input  wire       clk_i,
  input  wire       arst_n_i,
  input  wire       ce_i,
  input  wire       wr_en_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire [1:0] ref_i,
  output reg  [7:0] rdata_o,
  output reg        feedback_extend_sel_o,
  output reg        first_stage_bypass_o,
  output reg        osc_polarity_o,
  output reg        force_centre_o,
  output reg  [4:0] first_pump_code_o,
  output reg  [4:0] second_pump_code_o,
  output reg        offset_enable_o,
  output reg  [4:0] offset_code_o,
  output reg        osc_out_power_o,
  output reg        osc_out_format_o,
  output reg  [1:0] osc_out_amplitude_o,
  output reg        ref_sel_o,
  output reg        holdover_o,
  output reg  [1:0] loss_of_signal_o
);
  // ==========================================================
  // Reset release
  reg        rst_s1_q;
  reg        rst_n_q;
  // Two flops so release is clean against clk_i
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ==========================================================
  // Register file
  reg  [7:0] fbx_q;
  reg  [7:0] byp_q;
  reg  [7:0] loop_q;
  reg  [7:0] outofs_q;
  reg  [7:0] ampcp_q;
  reg  [7:0] prio_q;
  reg  [7:0] mode_q;
  reg  [7:0] hold_q;
  reg  [7:0] cntdiv_q;
  reg  [7:0] modhi_q;
  reg  [7:0] modlo_q;
  wire       sel_wr = wr_en_i && (addr_i == `RSVP_A_MODE);

  // Writes keep only defined bits
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fbx_q    <= `RSVP_R_ZERO;
      byp_q    <= `RSVP_R_ZERO;
      loop_q   <= `RSVP_R_LOOP;
      outofs_q <= `RSVP_R_ZERO;
      ampcp_q  <= `RSVP_R_AMPCP;
      prio_q   <= `RSVP_R_PRIO;
      mode_q   <= `RSVP_R_ZERO;
      hold_q   <= `RSVP_R_HOLD;
      cntdiv_q <= `RSVP_R_CNTDIV;
      modhi_q  <= `RSVP_R_ZERO;
      modlo_q  <= `RSVP_R_ZERO;
    end else if (ce_i && wr_en_i) begin
      case (addr_i)
        `RSVP_A_FBX:    fbx_q    <= wdata_i & `RSVP_M_FBX;
        `RSVP_A_BYP:    byp_q    <= wdata_i & `RSVP_M_BYP;
        `RSVP_A_LOOP:   loop_q   <= wdata_i & `RSVP_M_LOOP;
        `RSVP_A_OUTOFS: outofs_q <= wdata_i & `RSVP_M_OUTOFS;
        `RSVP_A_AMPCP:  ampcp_q  <= wdata_i & `RSVP_M_AMPCP;
        `RSVP_A_PRIO:   prio_q   <= wdata_i & `RSVP_M_PRIO;
        `RSVP_A_MODE:   mode_q   <= wdata_i & `RSVP_M_MODE;
        `RSVP_A_HOLD:   hold_q   <= wdata_i & `RSVP_M_HOLD;
        `RSVP_A_CNTDIV: cntdiv_q <= wdata_i & `RSVP_M_CNTDIV;
        `RSVP_A_MODHI:  modhi_q  <= wdata_i & `RSVP_M_MODHI;
        `RSVP_A_MODLO:  modlo_q  <= wdata_i & `RSVP_M_MODLO;
        default: ;
      endcase
    end
  end

  // Read mux, unmapped addresses answer zero
  reg  [7:0] rd_d;
  always @* begin
    case (addr_i)
      `RSVP_A_FBX:    rd_d = fbx_q;
      `RSVP_A_BYP:    rd_d = byp_q;
      `RSVP_A_LOOP:   rd_d = loop_q;
      `RSVP_A_OUTOFS: rd_d = outofs_q;
      `RSVP_A_AMPCP:  rd_d = ampcp_q;
      `RSVP_A_PRIO:   rd_d = prio_q;
      `RSVP_A_MODE:   rd_d = mode_q;
      `RSVP_A_HOLD:   rd_d = hold_q;
      `RSVP_A_CNTDIV: rd_d = cntdiv_q;
      `RSVP_A_MODHI:  rd_d = modhi_q;
      `RSVP_A_MODLO:  rd_d = modlo_q;
      default:        rd_d = `RSVP_R_ZERO;
    endcase
  end

  // Field aliases
  wire [1:0] prio0   = prio_q[7:6];
  wire [1:0] prio1   = prio_q[5:4];
  wire       prediv  = mode_q[5];
  wire       revertive_switching    = mode_q[4];
  wire [1:0] mode    = mode_q[3:2];
  wire [1:0] selfld  = mode_q[1:0];
  wire [1:0] hdiv    = cntdiv_q[7:6];
  wire [1:0] rvset   = cntdiv_q[1:0];
  wire [7:0] mod_en  = modhi_q | modlo_q;
  wire       auto_md = mode[0];

  // ==========================================================
  // Loss of signal and re-validation, one slice per input
  localparam [6:0] LOS_TO = LOS_TIMEOUT - 1;
  reg  [8:0] rv_load;
  // Load count from setting, times four with pre-divider
  always @* begin
    case (rvset)
      2'b00:   rv_load = `RSVP_RV_00;
      2'b01:   rv_load = `RSVP_RV_01;
      2'b10:   rv_load = `RSVP_RV_10;
      default: rv_load = `RSVP_RV_11;
    endcase
    if (prediv) begin
      rv_load = rv_load << `RSVP_PDIV_SH;
    end
  end

  wire [1:0] los_q;
  wire [1:0] reval_ev;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_in
      reg        prev_q;
      reg        lost_q;
      reg        reval_q;
      reg  [6:0] miss_q;
      reg  [8:0] rv_q;
      reg  [1:0] pd_q;
      wire       edge_w = ref_i[gi] && !prev_q;
      wire       miss_w = (miss_q == LOS_TO);
      wire       valid_w = !prediv || (pd_q == `RSVP_PDIV_TOP);
      // One driver per slice flag, gathered into the shared vectors
      assign los_q[gi]    = lost_q;
      assign reval_ev[gi] = reval_q;
      // Inputs are sampled at clk_i, so only slow refs are seen
      always @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
          prev_q      <= 1'b0;
          miss_q      <= 7'd0;
          rv_q        <= `RSVP_RV_11;
          pd_q        <= 2'd0;
          lost_q      <= 1'b1;
          reval_q     <= 1'b0;
        end else if (ce_i) begin
          prev_q       <= ref_i[gi];
          reval_q      <= 1'b0;
          if (edge_w || miss_w) begin
            miss_q <= 7'd0;
          end else begin
            miss_q <= miss_q + 7'd1;
          end
          if (miss_w) begin
            lost_q    <= 1'b1;
            rv_q      <= rv_load;
            pd_q      <= 2'd0;
          end else if (edge_w && lost_q) begin
            pd_q <= pd_q + 2'd1;
            if (valid_w) begin
              if (rv_q <= 9'd1) begin
                lost_q       <= 1'b0;
                reval_q      <= 1'b1;
                rv_q         <= rv_load;
              end else begin
                rv_q <= rv_q - 9'd1;
              end
            end
          end else if (!lost_q) begin
            rv_q <= rv_load;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Hold-off tick prescaler from the oscillator timebase
  reg  [`RSVP_PRE_W-1:0] pre_q;
  localparam [4:0]       HDB      = HOLD_DIV_BASE;
  wire [`RSVP_PRE_W-1:0] pre_one  = {{(`RSVP_PRE_W-1){1'b0}}, 1'b1};
  wire [4:0]             pre_sh   = HDB + {3'b000, hdiv};
  wire [`RSVP_PRE_W-1:0] pre_mask = (pre_one << pre_sh) - pre_one;
  wire                   tick     = ((pre_q & pre_mask) == pre_mask);
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pre_q <= {`RSVP_PRE_W{1'b0}};
    end else if (ce_i) begin
      pre_q <= pre_q + pre_one;
    end
  end

  // ==========================================================
  // Reference selection
  localparam [1:0] ST_RUN  = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;
  reg  [1:0] st_q;
  reg  [7:0] hcnt_q;
  reg        cur_q;
  reg        seed_q;
  wire       field_in = (selfld == `RSVP_SEL_IN1);
  wire       cur_los  = cur_q ? los_q[1] : los_q[0];
  wire       oth_los  = cur_q ? los_q[0] : los_q[1];
  wire [1:0] cur_pr   = cur_q ? prio1 : prio0;
  wire [1:0] oth_pr   = cur_q ? prio0 : prio1;
  // Ties favour input 0
  wire       best     = los_q[0] ? 1'b1 : (prio1 > prio0) && !los_q[1];
  wire       oth_rev  = cur_q ? reval_ev[0] : reval_ev[1];
  // Revertive only matters in the automatic modes
  wire       revert   = auto_md && revertive_switching && oth_rev &&
                        (oth_pr > cur_pr);
  wire       hmode    = (mode == `RSVP_MD_HOLD);

  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q   <= ST_RUN;
      hcnt_q <= `RSVP_R_HOLD;
      cur_q  <= 1'b0;
      seed_q <= 1'b0;
    end else if (ce_i) begin
      seed_q <= sel_wr;
      if (mode == `RSVP_MD_MAN) begin
        cur_q <= field_in;
        st_q  <= ST_RUN;
      end else if (auto_md) begin
        st_q <= ST_RUN;
        if (cur_los && !oth_los) begin
          cur_q <= best;
        end else if (revert) begin
          cur_q <= !cur_q;
        end
      end else if (hmode) begin
        // Short-term holdover: field seeds, failover overrides.
        // Seeding waits a cycle so a write that enters this mode counts.
        if (seed_q) begin
          cur_q <= field_in;
        end
        case (st_q)
          ST_RUN: begin
            hcnt_q <= hold_q;
            if (cur_los) begin
              st_q <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (!cur_los) begin
              st_q <= ST_RUN;
            end else if (tick) begin
              if (hcnt_q <= 8'd1) begin
                cur_q  <= !cur_q;
                hcnt_q <= hold_q;
                st_q   <= ST_RUN;
              end else begin
                hcnt_q <= hcnt_q - 8'd1;
              end
            end
          end
          default: st_q <= ST_RUN;
        endcase
      end
    end
  end

  // ==========================================================
  // Registered outputs
  wire       unlock = (mod_en == `RSVP_UNLOCK);
  wire       hold_auto = (mode == `RSVP_MD_AUTOH);
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_o               <= `RSVP_R_ZERO;
      feedback_extend_sel_o <= 1'b0;
      first_stage_bypass_o  <= 1'b0;
      osc_polarity_o        <= 1'b0;
      force_centre_o        <= 1'b1;
      first_pump_code_o     <= `RSVP_R_CPV;
      second_pump_code_o    <= `RSVP_R_CPF;
      offset_enable_o       <= 1'b0;
      offset_code_o         <= 5'd0;
      osc_out_power_o       <= `RSVP_ST_PWR;
      osc_out_format_o      <= `RSVP_ST_FMT;
      osc_out_amplitude_o   <= `RSVP_ST_AMP;
      ref_sel_o             <= 1'b0;
      holdover_o            <= 1'b0;
      loss_of_signal_o      <= 2'b11;
    end else if (ce_i) begin
      rdata_o               <= rd_d;
      feedback_extend_sel_o <= fbx_q[0];
      first_stage_bypass_o  <= byp_q[0];
      osc_polarity_o        <= loop_q[7];
      force_centre_o        <= loop_q[6];
      first_pump_code_o     <= loop_q[4:0];
      second_pump_code_o    <= ampcp_q[4:0];
      offset_enable_o       <= outofs_q[5];
      offset_code_o         <= outofs_q[5] ? outofs_q[4:0] : 5'd0;
      // Anything but the pattern falls back to startup settings
      if (unlock) begin
        osc_out_power_o     <= outofs_q[7];
        osc_out_format_o    <= outofs_q[6];
        osc_out_amplitude_o <= ampcp_q[6:5];
      end else begin
        osc_out_power_o     <= `RSVP_ST_PWR;
        osc_out_format_o    <= `RSVP_ST_FMT;
        osc_out_amplitude_o <= `RSVP_ST_AMP;
      end
      ref_sel_o             <= cur_q;
      holdover_o            <= hold_auto && los_q[0] && los_q[1];
      loss_of_signal_o      <= los_q;
    end
  end
endmodule // rsvp_ctrl

// ==== design/rsvp_map.vh ====
// Register map, field layout and reset values of the PLL control block
`ifndef RSVP_MAP_VH
`define RSVP_MAP_VH
// ==========================================================
// Register addresses
`define RSVP_A_FBX     8'h03
`define RSVP_A_BYP     8'h0A
`define RSVP_A_LOOP    8'h10
`define RSVP_A_OUTOFS  8'h11
`define RSVP_A_AMPCP   8'h12
`define RSVP_A_PRIO    8'h14
`define RSVP_A_MODE    8'h15
`define RSVP_A_HOLD    8'h16
`define RSVP_A_CNTDIV  8'h17
`define RSVP_A_MODHI   8'h1C
`define RSVP_A_MODLO   8'h1F
// ==========================================================
// Writable bit masks, reserved bits stay zero
`define RSVP_M_FBX     8'h01
`define RSVP_M_BYP     8'h01
`define RSVP_M_LOOP    8'hDF
`define RSVP_M_OUTOFS  8'hFF
`define RSVP_M_AMPCP   8'h7F
`define RSVP_M_PRIO    8'hF0
`define RSVP_M_MODE    8'h3F
`define RSVP_M_HOLD    8'hFF
`define RSVP_M_CNTDIV  8'hC3
`define RSVP_M_MODHI   8'hF0
`define RSVP_M_MODLO   8'h0F
// ==========================================================
// Reset values
`define RSVP_R_LOOP    8'h58
`define RSVP_R_AMPCP   8'h18
`define RSVP_R_PRIO    8'hE0
`define RSVP_R_HOLD    8'h80
`define RSVP_R_CNTDIV  8'h82
`define RSVP_R_ZERO    8'h00
`define RSVP_R_CPV     5'h18
`define RSVP_R_CPF     5'h18
// ==========================================================
// Oscillator output commit
`define RSVP_UNLOCK    8'h4B
`define RSVP_ST_PWR    1'b1
`define RSVP_ST_FMT    1'b1
`define RSVP_ST_AMP    2'b11
// ==========================================================
// Selection modes
`define RSVP_MD_MAN    2'b00
`define RSVP_MD_HOLD   2'b10
`define RSVP_MD_AUTOH  2'b11
`define RSVP_SEL_IN1   2'b01
// ==========================================================
// Re-validation loads (periods), and pre-divider shift
`define RSVP_RV_00     9'h002
`define RSVP_RV_01     9'h010
`define RSVP_RV_10     9'h020
`define RSVP_RV_11     9'h040
`define RSVP_PDIV_SH   2
`define RSVP_PDIV_TOP  2'b11
`define RSVP_PRE_W     20
`endif

// ==== tb/rsvp_ref_model.sv ====
// Behavioural model of the two redundant reference clock sources
`timescale 1ns/1ns
module rsvp_ref_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] run_i,
  output logic      [1:0] ref_o
);
  // ==========================================================
  // Toggle just after each edge; a stopped source freezes like a dead clock
  initial ref_o = 2'b00;
  always @(posedge clk_i) begin
    ref_o <= #2 ref_o ^ run_i;
  end
endmodule // rsvp_ref_model

// ==== tb/rsvp_ctrl_assertions.sv ====
// Concurrent checks on the ports of the PLL control block
`timescale 1ns/1ns
module rsvp_ctrl_assertions (
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic       ce_i,
  input wire logic       wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic       feedback_extend_sel_o,
  input wire logic       first_stage_bypass_o,
  input wire logic       osc_polarity_o,
  input wire logic       force_centre_o,
  input wire logic [4:0] first_pump_code_o,
  input wire logic [4:0] second_pump_code_o,
  input wire logic       offset_enable_o,
  input wire logic [4:0] offset_code_o,
  input wire logic       osc_out_power_o,
  input wire logic       osc_out_format_o,
  input wire logic [1:0] osc_out_amplitude_o,
  input wire logic       ref_sel_o,
  input wire logic [1:0] loss_of_signal_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================================
  // Two edges: the register takes the write, then the output flop takes the register
  property p_fbx;
    ce_i && wr_en_i && addr_i == 8'h03 |-> ##2
      feedback_extend_sel_o == $past(wdata_i[0], 2);
  endproperty
  a_fbx: assert property (p_fbx) else $error("feedback select off");
  property p_byp;
    ce_i && wr_en_i && addr_i == 8'h0A |-> ##2
      first_stage_bypass_o == $past(wdata_i[0], 2);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass off");
  property p_loop;
    ce_i && wr_en_i && addr_i == 8'h10 |-> ##2
      {osc_polarity_o, force_centre_o, first_pump_code_o} ==
      {$past(wdata_i[7:6], 2), $past(wdata_i[4:0], 2)};
  endproperty
  a_loop: assert property (p_loop) else $error("loop fields off");
  property p_ofs;
    ce_i && wr_en_i && addr_i == 8'h11 |-> ##2
      offset_code_o == ($past(wdata_i[5], 2) ? $past(wdata_i[4:0], 2) : 5'h00);
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset code off");
  property p_cpf;
    ce_i && wr_en_i && addr_i == 8'h12 |-> ##2
      second_pump_code_o == $past(wdata_i[4:0], 2);
  endproperty
  a_cpf: assert property (p_cpf) else $error("second pump off");
  property p_start;
    ce_i && wr_en_i && addr_i == 8'h1F && wdata_i[3:0] != 4'hB |-> ##2
      {osc_out_power_o, osc_out_format_o, osc_out_amplitude_o} == 4'hF;
  endproperty
  a_start: assert property (p_start) else $error("startup lost");
  // ==========================================================
  // Reserved bits read zero
  property p_res0a;
    ce_i && addr_i == 8'h0A |=> (rdata_o & 8'hFE) == 8'h00;
  endproperty
  a_res0a: assert property (p_res0a) else $error("reserved set");
  property p_res14;
    ce_i && addr_i == 8'h14 |=> rdata_o[3:0] == 4'h0;
  endproperty
  a_res14: assert property (p_res14) else $error("reserved set");
  // Frozen clock enable must not let the selection move
  property p_freeze;
    !ce_i |=> $stable({ref_sel_o, loss_of_signal_o});
  endproperty
  a_freeze: assert property (p_freeze) else $error("sel moved");
endmodule // rsvp_ctrl_assertions
bind rsvp_ctrl rsvp_ctrl_assertions u_rsvp_ctrl_assertions (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .wr_en_i(wr_en_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .feedback_extend_sel_o(feedback_extend_sel_o),
  .first_stage_bypass_o(first_stage_bypass_o),
  .osc_polarity_o(osc_polarity_o), .force_centre_o(force_centre_o),
  .first_pump_code_o(first_pump_code_o),
  .second_pump_code_o(second_pump_code_o),
  .offset_enable_o(offset_enable_o), .offset_code_o(offset_code_o),
  .osc_out_power_o(osc_out_power_o), .osc_out_format_o(osc_out_format_o),
  .osc_out_amplitude_o(osc_out_amplitude_o), .ref_sel_o(ref_sel_o),
  .loss_of_signal_o(loss_of_signal_o));

// ==== tb/rsvp_ctrl_test.sv ====
// Self-checking testbench of the PLL control block
`timescale 1ns/1ns
module rsvp_ctrl_test;
  logic       clk_i    = 1'b0;
  logic       arst_n_i = 1'b0;
  logic       ce_i     = 1'b1;
  logic       wr_en_i  = 1'b0;
  logic [7:0] addr_i   = 8'h00;
  logic [7:0] wdata_i  = 8'h00;
  logic [1:0] run      = 2'b11;
  logic [7:0] rd_q;
  wire  [1:0] ref_i;
  wire  [7:0] rdata_o;
  wire  [4:0] first_pump_code_o, second_pump_code_o, offset_code_o;
  wire  [1:0] osc_out_amplitude_o, loss_of_signal_o;
  wire        feedback_extend_sel_o, first_stage_bypass_o, osc_polarity_o;
  wire        force_centre_o, offset_enable_o, osc_out_power_o;
  wire        osc_out_format_o, ref_sel_o, holdover_o;
  wire  [3:0] osc_cfg = {osc_out_power_o, osc_out_format_o,
                         osc_out_amplitude_o};
  wire  [7:0] ctl_bits = {5'h00, feedback_extend_sel_o,
                          first_stage_bypass_o, osc_polarity_o};
  wire  [7:0] loop_bits = {osc_polarity_o, force_centre_o, 1'b0,
                           first_pump_code_o};
  wire  [7:0] ofs_bits = {offset_enable_o, 2'b00, offset_code_o};
  int         fail_count   = 0;
  int         total_checks = 0;
  int         cycles       = 0;
  logic [7:0] radr [7] = '{8'h10, 8'h12, 8'h14, 8'h15, 8'h16, 8'h17, 8'h11};
  logic [7:0] rval [7] = '{8'h58, 8'h18, 8'hE0, 8'h00, 8'h80, 8'h82, 8'h00};
  logic [7:0] madr [12] = '{8'h03, 8'h0A, 8'h10, 8'h11, 8'h12, 8'h14,
                            8'h15, 8'h16, 8'h17, 8'h1C, 8'h1F, 8'h20};
  logic [7:0] mval [12] = '{8'h01, 8'h01, 8'hDF, 8'hFF, 8'h7F, 8'hF0,
                            8'h3F, 8'hFF, 8'hC3, 8'hF0, 8'h0F, 8'h00};
  // ==========================================================
  // Clock, design and reference sources
  initial forever #20 clk_i = ~clk_i;
  rsvp_ctrl #(.LOS_TIMEOUT(8), .HOLD_DIV_BASE(2)) u_rsvp_ctrl (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .wr_en_i(wr_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .ref_i(ref_i), .rdata_o(rdata_o),
    .feedback_extend_sel_o(feedback_extend_sel_o),
    .first_stage_bypass_o(first_stage_bypass_o),
    .osc_polarity_o(osc_polarity_o), .force_centre_o(force_centre_o),
    .first_pump_code_o(first_pump_code_o),
    .second_pump_code_o(second_pump_code_o),
    .offset_enable_o(offset_enable_o), .offset_code_o(offset_code_o),
    .osc_out_power_o(osc_out_power_o), .osc_out_format_o(osc_out_format_o),
    .osc_out_amplitude_o(osc_out_amplitude_o), .ref_sel_o(ref_sel_o),
    .holdover_o(holdover_o), .loss_of_signal_o(loss_of_signal_o));
  rsvp_ref_model u_rsvp_ref_model (.clk_i(clk_i), .run_i(run), .ref_o(ref_i));
  // ==========================================================
  // Shared tasks
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Write, then let two edges pass so the control outputs have settled
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i); #1;
    wr_en_i = 1'b1;
    addr_i = a;
    wdata_i = d;
    @(posedge clk_i); #1;
    wr_en_i = 1'b0;
    @(posedge clk_i); #1;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_i); #1;
    addr_i = a;
    @(posedge clk_i); #1;
    rd_q = rdata_o;
  endtask
  // Bounded wait on holdover, selection and loss flags, then compare
  task wsel(input string name, input logic [3:0] exp, input int n);
    // Polled 1 ns after each edge, once the flops have settled
    for (int i = 0; i < n && {holdover_o, ref_sel_o, loss_of_signal_o}
         !== exp; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(name, {4'h0, holdover_o, ref_sel_o, loss_of_signal_o}, {4'h0, exp});
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      final_report;
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("centre", {7'h0, force_centre_o}, 8'h01);
    chk("pump1", {3'h0, first_pump_code_o}, 8'h18);
    chk("pump2", {3'h0, second_pump_code_o}, 8'h18);
    chk("osc", {4'h0, osc_cfg}, 8'h0F);
    chk("ctl", ctl_bits, 8'h00);
    for (int i = 0; i < 7; i++) begin
      rd(radr[i]);
      chk("reset reg", rd_q, rval[i]);
    end
    for (int i = 0; i < 12; i++) begin
      wr(madr[i], 8'hFF);
      rd(madr[i]);
      chk("mask", rd_q, mval[i]);
    end
    chk("fbx byp", ctl_bits, 8'h07);
    chk("loop", loop_bits, 8'hDF);
    chk("ofs", ofs_bits, 8'h9F);
    wr(8'h15, 8'h00);
    wr(8'h16, 8'h02);
    wr(8'h17, 8'h00);
    wr(8'h14, 8'hE0);
    wr(8'h10, 8'h00);
    chk("centre off", {force_centre_o, osc_polarity_o}, 8'h00);
    wr(8'h11, 8'h1F);
    chk("ofs off", ofs_bits, 8'h00);
    // Output config waits for the unlock pattern
    wr(8'h11, 8'h40);
    wr(8'h12, 8'h20);
    chk("osc held", {4'h0, osc_cfg}, 8'h0F);
    wr(8'h1C, 8'h40);
    wr(8'h1F, 8'h0B);
    chk("osc new", {4'h0, osc_cfg}, 8'h05);
    wr(8'h1F, 8'h00);
    chk("osc back", {4'h0, osc_cfg}, 8'h0F);
    // Writes are dropped while the clock enable is low
    ce_i = 1'b0;
    wr(8'h16, 8'h55);
    ce_i = 1'b1;
    rd(8'h16);
    chk("frozen", rd_q, 8'h02);
    // Reference selection through the modes
    wsel("revalid", 4'b0000, 300);
    wr(8'h15, 8'h01);
    wsel("manual 1", 4'b0100, 20);
    wr(8'h15, 8'h00);
    wsel("manual 0", 4'b0000, 20);
    wr(8'h15, 8'h14);
    run = 2'b10;
    wsel("auto fail", 4'b0101, 60);
    run = 2'b11;
    wsel("revert", 4'b0000, 60);
    wr(8'h15, 8'h04);
    run = 2'b10;
    wsel("auto fail2", 4'b0101, 60);
    run = 2'b11;
    wsel("no revert", 4'b0100, 60);
    repeat (20) @(posedge clk_i);
    chk("no revert", {7'h0, ref_sel_o}, 8'h01);
    wr(8'h15, 8'h0C);
    // Spare input drops first and the selected one returns first, so
    // the outcome does not hang on the two sources' relative phase
    run = 2'b10;
    wsel("hold pre", 4'b0101, 60);
    run = 2'b00;
    wsel("holdover", 4'b1111, 60);
    run = 2'b10;
    wsel("hold back", 4'b0101, 60);
    run = 2'b11;
    wsel("hold end", 4'b0100, 60);
    wr(8'h15, 8'h08);
    wsel("hold seed", 4'b0000, 20);
    wr(8'h15, 8'h09);
    run = 2'b01;
    wsel("hold wait", 4'b0110, 60);
    wsel("hold swap", 4'b0010, 40);
    run = 2'b11;
    final_report;
  end
endmodule // rsvp_ctrl_test
